// file: rtl/mpsc_pkg.sv
// package: constants and types shared by both ends of the modem power-state link
package mpsc_pkg;
	localparam int unsigned MPSC_CLK_HZ = 50_000_000;
	localparam int unsigned MPSC_INIT_MS = 220;
	localparam int unsigned MPSC_SHUT_READY_MS = 75;
	localparam int unsigned MPSC_INIT_CYC = (MPSC_CLK_HZ / 1000) * MPSC_INIT_MS;
	localparam int unsigned MPSC_SHUT_READY_CYC = (MPSC_CLK_HZ / 1000) * MPSC_SHUT_READY_MS;
	localparam int unsigned MPSC_CNT_W = 24;
	localparam logic MPSC_DOZE_SEL_RST = 1'b0;
	localparam logic MPSC_CHAN_W = 1'b1;
	localparam logic [4:0] MPSC_CHAN_RST = 5'h00;
	typedef enum logic [1:0] {
		MPSC_CMD_NONE,
		MPSC_CMD_RADIO_OFF,
		MPSC_CMD_RADIO_ON
	} mpsc_cmd_t;
	typedef enum logic [2:0] {
		MPSC_ST_INIT,
		MPSC_ST_ACTIVE,
		MPSC_ST_DOZE,
		MPSC_ST_RF_DOWN,
		MPSC_ST_SHUT
	} mpsc_state_t;
endpackage

// file: rtl/mpsc_link_if.sv
// interface: shutdown pin and command strobe between host and modem
interface mpsc_link_if;
	logic shut_n;
	logic cmd_valid;
	logic [1:0] cmd;
	logic cmd_ready;
	modport host (output shut_n, output cmd_valid, output cmd, input cmd_ready);
	modport modem (input shut_n, input cmd_valid, input cmd, output cmd_ready);
endinterface

// file: rtl/mpsc_modem.sv
// modem end: power-state sequencer for the radio modem
module mpsc_modem import mpsc_pkg::*; #(
	parameter int unsigned INIT_CYC = MPSC_INIT_CYC,
	parameter int unsigned SHUT_READY_CYC = MPSC_SHUT_READY_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	mpsc_link_if.modem link,
	input wire logic doze_sel,
	input wire logic doze_sel_we,
	input wire logic wake_pkt,
	input wire logic chan_we,
	input wire logic [4:0] chan_in,
	output logic radio_pwr,
	output logic rx_intermittent,
	output logic logic_run,
	output logic reg_access_ok,
	output logic [2:0] state,
	output logic doze_stored,
	output logic [4:0] chan
);
	mpsc_state_t st_q, st_d;
	logic [MPSC_CNT_W-1:0] cnt_q, cnt_d;
	logic doze_q, doze_d;
	logic [4:0] chan_q, chan_d;
	logic ready_q, ready_d;
	logic radio_q, radio_d;
	logic inter_q, inter_d;
	logic run_q, run_d;
	logic acc_q, acc_d;
	logic cmd_take;

	assign cmd_take = link.cmd_valid && ready_q;

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		doze_d = doze_q;
		chan_d = chan_q;
		ready_d = ready_q;
		if (doze_sel_we && ready_q) begin
			doze_d = doze_sel;
		end
		if (chan_we && ready_q) begin
			chan_d = chan_in;
		end
		if (!link.shut_n) begin
			st_d = MPSC_ST_SHUT;
			ready_d = 1'b0;
			chan_d = MPSC_CHAN_RST;
			cnt_d = '0;
			doze_d = doze_q;
		end else begin
			case (st_q)
				MPSC_ST_INIT: begin
					if (cnt_q >= MPSC_CNT_W'(INIT_CYC - 1)) begin
						st_d = doze_q ? MPSC_ST_DOZE : MPSC_ST_ACTIVE;
						ready_d = 1'b1;
					end else begin
						cnt_d = cnt_q + 1'b1;
					end
				end
				MPSC_ST_SHUT: begin
					if (cnt_q >= MPSC_CNT_W'(SHUT_READY_CYC - 1)) begin
						st_d = doze_q ? MPSC_ST_DOZE : MPSC_ST_ACTIVE;
						ready_d = 1'b1;
						cnt_d = '0;
					end else begin
						cnt_d = cnt_q + 1'b1;
					end
				end
				MPSC_ST_ACTIVE: begin
					if (cmd_take && link.cmd == MPSC_CMD_RADIO_OFF) begin
						st_d = MPSC_ST_RF_DOWN;
					end else if (doze_sel_we && doze_sel) begin
						st_d = MPSC_ST_DOZE;
					end
				end
				MPSC_ST_DOZE: begin
					if (wake_pkt) begin
						st_d = MPSC_ST_ACTIVE;
					end else if (cmd_take && link.cmd == MPSC_CMD_RADIO_OFF) begin
						st_d = MPSC_ST_RF_DOWN;
					end
				end
				MPSC_ST_RF_DOWN: begin
					if (cmd_take && link.cmd == MPSC_CMD_RADIO_ON) begin
						st_d = MPSC_ST_ACTIVE;
					end
				end
				default: begin
					st_d = MPSC_ST_INIT;
				end
			endcase
		end
	end

	always_comb begin
		radio_d = (st_d == MPSC_ST_ACTIVE) || (st_d == MPSC_ST_DOZE);
		inter_d = (st_d == MPSC_ST_DOZE);
		run_d = (st_d != MPSC_ST_SHUT);
		acc_d = ready_d;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= MPSC_ST_INIT;
			cnt_q <= '0;
			doze_q <= MPSC_DOZE_SEL_RST;
			chan_q <= MPSC_CHAN_RST;
			ready_q <= 1'b0;
			radio_q <= 1'b0;
			inter_q <= 1'b0;
			run_q <= 1'b1;
			acc_q <= 1'b0;
		end else if (clk_en) begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			doze_q <= doze_d;
			chan_q <= chan_d;
			ready_q <= ready_d;
			radio_q <= radio_d;
			inter_q <= inter_d;
			run_q <= run_d;
			acc_q <= acc_d;
		end
	end

	assign link.cmd_ready = ready_q;
	assign radio_pwr = radio_q;
	assign rx_intermittent = inter_q;
	assign logic_run = run_q;
	assign reg_access_ok = acc_q;
	assign state = st_q;
	assign doze_stored = doze_q;
	assign chan = chan_q;
endmodule

// file: rtl/mpsc_host.sv
// host end: drives shutdown pin and radio on/off commands
module mpsc_host import mpsc_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	mpsc_link_if.host link,
	input wire logic shut_req,
	input wire logic off_req,
	input wire logic on_req,
	output logic busy
);
	logic shut_n_q, shut_n_d;
	logic valid_q, valid_d;
	logic [1:0] cmd_q, cmd_d;

	always_comb begin
		shut_n_d = !shut_req;
		valid_d = valid_q;
		cmd_d = cmd_q;
		if (valid_q && link.cmd_ready) begin
			valid_d = 1'b0;
		end
		if (!valid_d && shut_n_q && link.cmd_ready) begin
			if (off_req) begin
				valid_d = 1'b1;
				cmd_d = MPSC_CMD_RADIO_OFF;
			end else if (on_req) begin
				valid_d = 1'b1;
				cmd_d = MPSC_CMD_RADIO_ON;
			end
		end
		if (shut_req) begin
			valid_d = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			shut_n_q <= 1'b1;
			valid_q <= 1'b0;
			cmd_q <= MPSC_CMD_NONE;
		end else if (clk_en) begin
			shut_n_q <= shut_n_d;
			valid_q <= valid_d;
			cmd_q <= cmd_d;
		end
	end

	assign link.shut_n = shut_n_q;
	assign link.cmd_valid = valid_q;
	assign link.cmd = cmd_q;
	assign busy = valid_q;
endmodule

// file: verif/mpsc_props.sv
// checker: timing of the shutdown pin and command handshake
module mpsc_props #(
	parameter int INIT_CYC = 20,
	parameter int SHUT_READY_CYC = 10
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic shut_n,
	input wire logic cmd_valid,
	input wire logic [1:0] cmd,
	input wire logic cmd_ready
);
	localparam int IN_MAX = INIT_CYC + 4;
	localparam int SR_MAX = SHUT_READY_CYC + 4;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_init_quiet: assert property ($fell(sys_rst) |-> !cmd_ready [*8])
		else $error("ready too soon after reset");
	a_init_ready: assert property ($fell(sys_rst) |-> ##[1:IN_MAX] cmd_ready)
		else $error("ready never came after reset");
	a_shut_drop: assert property (!shut_n |=> !cmd_ready)
		else $error("ready kept while shut");
	a_shut_quiet: assert property ($rose(shut_n) |-> !cmd_ready [*8])
		else $error("ready too soon after shut");
	a_shut_ready: assert property ($rose(shut_n) |-> ##[1:SR_MAX] cmd_ready)
		else $error("ready never came after shut");
	a_valid_drops: assert property (cmd_valid && cmd_ready && shut_n |=> !cmd_valid)
		else $error("valid kept after take");
	a_valid_holds: assert property (cmd_valid && !cmd_ready && shut_n |=> cmd_valid)
		else $error("valid dropped untaken");
	a_cmd_code: assert property (cmd_valid |-> cmd inside {2'h1, 2'h2})
		else $error("bad command code");
endmodule

// file: verif/mpsc_tb_top.sv
// testbench: host and modem ends joined over the link
module mpsc_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import mpsc_pkg::*;
	logic clk = 0, sys_rst = 1, shut_req = 0, off_req = 0, on_req = 0, busy, clk_en = 1;
	logic doze_sel = 0, doze_sel_we = 0, wake_pkt = 0, chan_we = 0, pwr, rxi, run, rok, dz;
	logic [4:0] chan_in = 5'h0a, chan;
	logic [2:0] state;
	logic [4:0] rows [4] = '{5'h16, 5'h16, 5'h03, 5'h03};
	int fail_count = 0, check_count = 0;
	always #10 clk = ~clk;
	mpsc_link_if lnk();
	mpsc_host i_mpsc_host(.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .link(lnk),
		.shut_req(shut_req), .off_req(off_req), .on_req(on_req), .busy(busy));
	mpsc_modem #(.INIT_CYC(20), .SHUT_READY_CYC(10)) i_mpsc_modem(.clk(clk),
		.sys_rst(sys_rst), .clk_en(clk_en), .link(lnk), .doze_sel(doze_sel),
		.doze_sel_we(doze_sel_we), .wake_pkt(wake_pkt), .chan_we(chan_we), .chan_in(chan_in),
		.radio_pwr(pwr), .rx_intermittent(rxi), .logic_run(run), .reg_access_ok(rok),
		.state(state), .doze_stored(dz), .chan(chan));
	mpsc_props #(.INIT_CYC(20), .SHUT_READY_CYC(10)) i_mpsc_props(.clk(clk),
		.sys_rst(sys_rst), .shut_n(lnk.shut_n), .cmd_valid(lnk.cmd_valid), .cmd(lnk.cmd),
		.cmd_ready(lnk.cmd_ready));
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string what, input logic [4:0] exp, input logic [4:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic wait_rdy;
		int n;
		n = 0;
		while (lnk.cmd_ready !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		if (n == 100) begin
			fail_count++;
			final_report();
		end
	endtask
	task automatic send(input logic off);
		off_req = off;
		on_req = !off;
		@(negedge clk);
		chk("busy", 5'h01, 5'(busy)); // request raised
		off_req = 0;
		on_req = 0;
		@(negedge clk);
		chk("busy", 5'h00, 5'(busy)); // request taken
	endtask
	task automatic pulse(input int k);
		if (k == 0) doze_sel_we = 1;
		else if (k == 1) wake_pkt = 1;
		else chan_we = 1;
		@(negedge clk);
		doze_sel_we = 0;
		wake_pkt = 0;
		chan_we = 0;
	endtask
	initial begin
		repeat (4) @(negedge clk);
		sys_rst = 0;
		chk("init", 5'(MPSC_ST_INIT), 5'(state)); // init state
		wait_rdy();
		chk("active", 5'(MPSC_ST_ACTIVE), 5'(state)); // power-up
		chk("radio", 5'h01, 5'(pwr)); // radio on
		pulse(2);
		for (int i = 0; i < 4; i++) begin
			send(rows[i][4]);
			chk("state", 5'(rows[i][3:1]), 5'(state)); // off/on
			chk("radio", 5'(rows[i][0]), 5'(pwr)); // rf power
			chk("chan", 5'h0a, chan); // kept
			chk("regs", 5'h01, 5'(rok)); // regs open
			$display("row %0d done", i);
		end
		doze_sel = 1;
		pulse(0);
		chk("doze", 5'(MPSC_ST_DOZE), 5'(state)); // doze entry
		chk("rx", 5'h01, 5'(rxi)); // intermittent
		shut_req = 1;
		repeat (2) @(negedge clk);
		chk("shut", 5'(MPSC_ST_SHUT), 5'(state)); // pin low
		chk("run", 5'h00, 5'(run)); // logic stops
		chk("chan", 5'h00, chan); // reverts
		shut_req = 0;
		wait_rdy();
		chk("resume", 5'(MPSC_ST_DOZE), 5'(state)); // back to doze
		chk("dz", 5'h01, 5'(dz)); // doze kept
		pulse(1);
		chk("wake", 5'(MPSC_ST_ACTIVE), 5'(state)); // wake packet
		clk_en = 0;
		off_req = 1;
		repeat (3) @(negedge clk);
		chk("frozen", 5'(MPSC_ST_ACTIVE), 5'(state)); // enable low holds
		chk("frozen busy", 5'h00, 5'(busy)); // host held
		off_req = 0;
		clk_en = 1;
		@(negedge clk);
		$display("enable tests done");
		$display("power tests done");
		sys_rst = 1;
		repeat (4) @(negedge clk);
		sys_rst = 0;
		chk("rst", 5'(MPSC_ST_INIT), 5'(state)); // second reset
		chk("rst dz", 5'h00, 5'(dz)); // stored default
		wait_rdy();
		final_report();
	end
endmodule
